// [design/cosl_pkg.sv]
package cosl_pkg;
   // register byte offsets on the ahb-lite slave
   localparam logic [7:0] REG_CONFIG = 8'h00;
   localparam logic [7:0] REG_LOOP_ONE = 8'h04;
   localparam logic [7:0] REG_LOOP_TWO = 8'h08;
   localparam logic [7:0] REG_SETPOINT = 8'h0c;
   localparam logic [7:0] REG_VIEW = 8'h10;
   localparam int ADDR_W = 8;

   // build options written by software, bit 0 is two_loop
   typedef struct packed {
      logic contact_loop_two;
      logic contact_loop_one;
      logic contact_selected_setpoint;
      logic cascade;
      logic two_input;
      logic feedback;
      logic servo_function;
      logic two_output;
      logic two_loop;
   } cosl_config_t;

   // state of one control loop, bit 0 is standby_flag
   typedef struct packed {
      logic far_setpoint_source;
      logic error;
      logic preset;
      logic pot_error;
      logic manual;
      logic autotune_hold;
      logic autotune_flag;
      logic ramp_pause;
      logic ramp_active_flag;
      logic standby_flag;
   } cosl_status_t;

   typedef enum logic [2:0] {
      SRC_MANUAL = 3'h0,
      SRC_POT_ERROR = 3'h1,
      SRC_STANDBY = 3'h2,
      SRC_PRESET = 3'h3,
      SRC_ERROR = 3'h4,
      SRC_PID = 3'h5
   } cosl_src_t;

   typedef enum logic [2:0] {
      SCR_MAIN = 3'h0,
      SCR_OUTPUT = 3'h1,
      SCR_MEASURED = 3'h2,
      SCR_STATUS = 3'h3,
      SCR_OTHER = 3'h4
   } cosl_screen_t;

   typedef enum logic [1:0] {
      MODE_ONE = 2'h0,
      MODE_TWO = 2'h1,
      MODE_THREE = 2'h2
   } cosl_mode_t;

   // key bit positions
   localparam int KEY_SETPOINT = 0;
   localparam int KEY_VIEW = 1;
   localparam int KEY_GROUP = 2;
   localparam int KEY_CONFIRM = 3;
   localparam int KEY_UP = 4;
   localparam int KEY_DOWN = 5;
   localparam int KEY_SELECT = 6;
   localparam int KEY_SCREEN = 7;
   localparam int NUM_KEYS = 8;

   // lamp bit positions
   localparam int LAMP_STANDBY = 0;
   localparam int LAMP_RAMP = 1;
   localparam int LAMP_CONTACT = 2;
   localparam int LAMP_AUTOTUNE = 3;
   localparam int LAMP_MANUAL = 4;
   localparam int LAMP_REMOTE = 5;
   localparam int NUM_LAMPS = 6;

   // timebase
   localparam int CLK_HZ = 25000000;
   localparam int TICK_MS = 10;
   localparam int TICK_CYCLES_DEFAULT = CLK_HZ / 1000 * TICK_MS;
   localparam int TICK_W = 20;
   localparam int BLINK_MS = 250;
   localparam logic [4:0] BLINK_TICKS = 5'(BLINK_MS / TICK_MS);
   localparam int SP_W = 4;
endpackage : cosl_pkg

// [design/cosl_front_panel.sv]
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module cosl_front_panel
   import cosl_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NUM_KEYS-1:0] keys,
   input wire logic [SP_W-1:0] contact_setpoint_select,
   output logic [NUM_LAMPS-1:0] status_lamps,
   output logic loop_two_lamp,
   output logic measured_value_loop,
   output logic setpoint_loop,
   output logic [SP_W-1:0] setpoint_number,
   output logic setpoint_number_blink,
   output logic [2:0] screen,
   output logic [NUM_LAMPS-1:0] monitor_lamps,
   output logic monitor_loop,
   output logic [2:0] loop_one_source,
   output logic [2:0] loop_two_source,
   output logic motor_open,
   output logic motor_close,
   output logic output_increment,
   output logic output_decrement,
   output logic adjust_secondary,
   output logic show_secondary_control_output,
   output logic show_position
);

   typedef struct packed {
      cosl_config_t cfg;
      cosl_status_t st1;
      cosl_status_t st2;
      logic [NUM_KEYS-1:0] key_s1;
      logic [NUM_KEYS-1:0] key_s2;
      logic [NUM_KEYS-1:0] key_samp;
      logic [NUM_KEYS-1:0] key_deb;
      logic [SP_W-1:0] contact_s1;
      logic [SP_W-1:0] contact_s2;
      logic [TICK_W-1:0] tick_cnt;
      logic tick;
      logic [4:0] blink_cnt;
      logic blink;
      cosl_screen_t scr;
      cosl_mode_t mode;
      logic editing;
      logic [SP_W-1:0] edit_no;
      logic [SP_W-1:0] sp1;
      logic [SP_W-1:0] sp2;
      logic adjust_sel;
      logic [NUM_LAMPS-1:0] lamps;
      logic [NUM_LAMPS-1:0] mon_lamps;
      logic lamp_two;
      logic meas_loop;
      logic sp_loop;
      logic mon_loop;
      logic [SP_W-1:0] sp_shown;
      logic sp_blink;
      cosl_src_t src1;
      cosl_src_t src2;
      logic m_open;
      logic m_close;
      logic out_inc;
      logic out_dec;
      logic show_second;
      logic show_pos;
      logic readyout;
      logic [31:0] rdata;
      logic ap_valid;
      logic ap_write;
      logic [ADDR_W-1:0] ap_addr;
   } cosl_state_t;

   cosl_state_t s;
   cosl_state_t n;

   // output source chain, manual first, then pot error, standby, preset, error, pid
   function automatic cosl_src_t pick_source(cosl_status_t st, cosl_config_t cfg);
      cosl_src_t src;
      if (st.manual) begin
         src = SRC_MANUAL;
      end else if (st.pot_error && cfg.servo_function && cfg.feedback) begin
         src = SRC_POT_ERROR;
      end else if (st.standby_flag) begin
         src = SRC_STANDBY;
      end else if (st.preset) begin
         src = SRC_PRESET;
      end else if (st.error) begin
         src = SRC_ERROR;
      end else begin
         src = SRC_PID;
      end
      return src;
   endfunction : pick_source

   // six lamps of one loop; blink is the shared phase
   function automatic logic [NUM_LAMPS-1:0] make_lamps(cosl_status_t st, logic contact,
                                                        logic blink);
      logic [NUM_LAMPS-1:0] l;
      l = '0;
      l[LAMP_STANDBY] = st.standby_flag & blink;
      l[LAMP_RAMP] = st.ramp_active_flag ? blink : st.ramp_pause;
      l[LAMP_CONTACT] = contact;
      l[LAMP_AUTOTUNE] = st.autotune_flag ? blink : st.autotune_hold;
      l[LAMP_MANUAL] = st.manual & blink;
      l[LAMP_REMOTE] = st.far_setpoint_source;
      return l;
   endfunction : make_lamps

   logic [NUM_KEYS-1:0] press;
   logic [NUM_KEYS-1:0] deb_next;
   logic sel_two;
   logic locked;
   logic [SP_W-1:0] cur_sp;
   logic adj_manual;
   logic contact_one;
   logic contact_two;

   always_comb begin
      n = s;
      press = '0;
      deb_next = s.key_deb;
      sel_two = 1'b0;
      locked = 1'b0;
      cur_sp = '0;
      adj_manual = 1'b0;
      contact_one = 1'b0;
      contact_two = 1'b0;

      // two-stage synchronisers for keys and contacts
      n.key_s1 = keys;
      n.key_s2 = s.key_s1;
      n.contact_s1 = contact_setpoint_select;
      n.contact_s2 = s.contact_s1;

      // common tick: keys are sampled and lamps blink from it
      n.tick = 1'b0;
      if (s.tick_cnt >= TICK_W'(TICK_CYCLES - 1)) begin
         n.tick_cnt = '0;
         n.tick = 1'b1;
      end else begin
         n.tick_cnt = s.tick_cnt + 1'b1;
      end
      if (s.tick) begin
         if (s.blink_cnt >= BLINK_TICKS - 5'h01) begin
            n.blink_cnt = '0;
            n.blink = ~s.blink;
         end else begin
            n.blink_cnt = s.blink_cnt + 5'h01;
         end
      end

      // debounce: a key level is taken once two ticks agree
      if (s.tick) begin
         n.key_samp = s.key_s2;
         for (int i = 0; i < NUM_KEYS; i++) begin
            if (s.key_s2[i] == s.key_samp[i]) begin
               deb_next[i] = s.key_s2[i];
            end
         end
      end
      n.key_deb = deb_next;
      press = deb_next & ~s.key_deb;

      // screen navigation
      if (!s.cfg.two_loop) begin
         n.mode = MODE_ONE;
      end
      if (press[KEY_GROUP]) begin
         n.scr = SCR_OTHER; // main view and mode stay as they were
         n.editing = 1'b0;
      end else if (press[KEY_VIEW]) begin
         if (s.scr == SCR_MAIN && s.cfg.two_loop && !s.editing) begin
            case (s.mode)
               MODE_ONE: n.mode = MODE_TWO;
               MODE_TWO: n.mode = MODE_THREE;
               default: n.mode = MODE_ONE;
            endcase
         end else begin
            n.scr = SCR_MAIN;
         end
      end else if (press[KEY_SCREEN] && !s.editing) begin
         case (s.scr)
            SCR_MAIN: n.scr = SCR_OUTPUT;
            SCR_OUTPUT: begin
               if (s.cfg.two_input) begin
                  n.scr = SCR_MEASURED;
               end else if (s.cfg.two_loop) begin
                  n.scr = SCR_STATUS;
               end else begin
                  n.scr = SCR_MAIN;
               end
            end
            SCR_MEASURED: n.scr = s.cfg.two_loop ? SCR_STATUS : SCR_MAIN;
            SCR_STATUS: n.scr = SCR_MAIN;
            default: n.scr = s.scr; // other groups page on their own
         endcase
      end

      // displayed channel follows the loop two lamp
      sel_two = (s.mode == MODE_TWO);
      n.lamp_two = (n.mode == MODE_TWO);
      n.meas_loop = (n.mode == MODE_TWO);
      n.sp_loop = (n.mode != MODE_ONE);
      n.mon_loop = ~n.meas_loop;

      // setpoint number editing for the displayed channel
      locked = (s.cfg.cascade && sel_two) || s.cfg.contact_selected_setpoint;
      cur_sp = sel_two ? s.sp2 : s.sp1;
      if (press[KEY_SETPOINT] && !press[KEY_GROUP]) begin
         if (s.scr != SCR_MAIN) begin
            n.scr = SCR_MAIN;
            n.editing = ~locked;
            n.edit_no = cur_sp;
         end else if (locked) begin
            n.editing = 1'b0;
         end else if (!s.editing) begin
            n.editing = 1'b1;
            n.edit_no = cur_sp + 1'b1;
         end else begin
            n.edit_no = s.edit_no + 1'b1;
         end
      end else if (s.editing) begin
         if (locked) begin
            n.editing = 1'b0; // a lock arriving mid-edit discards the edit
         end else if (press[KEY_UP]) begin
            n.edit_no = s.edit_no + 1'b1;
         end else if (press[KEY_DOWN]) begin
            n.edit_no = s.edit_no - 1'b1;
         end else if (press[KEY_CONFIRM]) begin
            n.editing = 1'b0;
            if (sel_two) begin
               n.sp2 = s.edit_no;
            end else begin
               n.sp1 = s.edit_no;
            end
         end
      end

      // contact selection overrides the assigned channels, except loop two in a cascade build
      contact_one = s.cfg.contact_selected_setpoint && s.cfg.contact_loop_one;
      contact_two = s.cfg.contact_selected_setpoint && s.cfg.contact_loop_two;
      if (contact_one) begin
         n.sp1 = s.contact_s2;
      end
      if (contact_two && !s.cfg.cascade) begin
         n.sp2 = s.contact_s2;
      end
      n.sp_shown = n.editing ? n.edit_no : (n.sp_loop ? n.sp2 : n.sp1);
      n.sp_blink = n.editing & n.blink;

      // output monitor: cursor and manual adjustment
      // a servo build with feedback uses its second row for position; no servo build shows a second output
      n.show_second = ~s.cfg.servo_function & (s.cfg.two_output | s.cfg.two_loop);
      n.show_pos = s.cfg.servo_function & s.cfg.feedback;
      if (s.cfg.servo_function || !(s.cfg.two_output || s.cfg.two_loop)) begin
         n.adjust_sel = 1'b0;
      end else if (press[KEY_SELECT] && s.scr == SCR_OUTPUT) begin
         n.adjust_sel = ~s.adjust_sel;
      end
      adj_manual = (s.cfg.two_loop && s.adjust_sel) ? s.st2.manual : s.st1.manual;
      n.m_open = 1'b0;
      n.m_close = 1'b0;
      n.out_inc = 1'b0;
      n.out_dec = 1'b0;
      if (s.scr == SCR_OUTPUT && adj_manual) begin
         if (s.cfg.servo_function) begin
            // held key drives the motor; both keys together drive nothing
            n.m_open = deb_next[KEY_UP] & ~deb_next[KEY_DOWN];
            n.m_close = deb_next[KEY_DOWN] & ~deb_next[KEY_UP];
         end else begin
            n.out_inc = press[KEY_UP];
            n.out_dec = press[KEY_DOWN];
         end
      end

      // lamps and sources
      contact_one = s.cfg.contact_selected_setpoint && s.cfg.contact_loop_one;
      n.lamps = n.meas_loop ? make_lamps(s.st2, contact_two, n.blink)
                          : make_lamps(s.st1, contact_one, n.blink);
      n.mon_lamps = n.mon_loop ? make_lamps(s.st2, contact_two, n.blink)
                               : make_lamps(s.st1, contact_one, n.blink);
      n.src1 = pick_source(s.st1, s.cfg);
      n.src2 = pick_source(s.st2, s.cfg);

      // ahb-lite slave: zero wait states, always okay
      n.readyout = 1'b1;
      if (s.ap_valid && s.ap_write) begin
         case (s.ap_addr)
            REG_CONFIG: n.cfg = hwdata[$bits(cosl_config_t)-1:0];
            REG_LOOP_ONE: n.st1 = hwdata[$bits(cosl_status_t)-1:0];
            REG_LOOP_TWO: n.st2 = hwdata[$bits(cosl_status_t)-1:0];
            default: n.cfg = n.cfg; // read-only or unmapped: ignored
         endcase
      end
      n.ap_valid = hsel && hready && htrans[1];
      if (hsel && hready) begin
         n.ap_write = hwrite;
         n.ap_addr = {haddr[ADDR_W-1:2], 2'b00};
      end
      // read data built from next values so a write just before is seen
      n.rdata = '0;
      if (hsel && hready && htrans[1] && !hwrite) begin
         case ({haddr[ADDR_W-1:2], 2'b00})
            REG_CONFIG: n.rdata = 32'(n.cfg);
            REG_LOOP_ONE: n.rdata = 32'(n.st1);
            REG_LOOP_TWO: n.rdata = 32'(n.st2);
            REG_SETPOINT: n.rdata = 32'({n.editing, n.edit_no, n.sp2, n.sp1});
            REG_VIEW: n.rdata = 32'({n.src2, n.src1, n.adjust_sel, n.mode, n.scr});
            default: n.rdata = '0;
         endcase
      end
   end

   // single state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.readyout <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign hreadyout = s.readyout;
   assign hresp = 1'b0;
   assign hrdata = s.rdata;
   assign status_lamps = s.lamps;
   assign loop_two_lamp = s.lamp_two;
   assign measured_value_loop = s.meas_loop;
   assign setpoint_loop = s.sp_loop;
   assign setpoint_number = s.sp_shown;
   assign setpoint_number_blink = s.sp_blink;
   assign screen = s.scr;
   assign monitor_lamps = s.mon_lamps;
   assign monitor_loop = s.mon_loop;
   assign loop_one_source = s.src1;
   assign loop_two_source = s.src2;
   assign motor_open = s.m_open;
   assign motor_close = s.m_close;
   assign output_increment = s.out_inc;
   assign output_decrement = s.out_dec;
   assign adjust_secondary = s.adjust_sel;
   assign show_secondary_control_output = s.show_second;
   assign show_position = s.show_pos;

endmodule : cosl_front_panel

// [dv/cosl_front_panel_sva.sv]
`timescale 1ns/100ps
module cosl_checker
   import cosl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [2:0] screen,
   input wire logic setpoint_number_blink,
   input wire logic loop_two_lamp,
   input wire logic measured_value_loop,
   input wire logic monitor_loop,
   input wire logic [2:0] loop_one_source,
   input wire logic [2:0] loop_two_source,
   input wire logic motor_open,
   input wire logic motor_close,
   input wire logic output_increment,
   input wire logic output_decrement,
   input wire logic adjust_secondary,
   input wire logic show_position
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // a cycle with no read address phase leaves the next data phase empty
   sequence s_no_read;
      !(hsel && hready && htrans[1] && !hwrite);
   endsequence
   // a motor drive is a level that lasts at least two cycles
   sequence s_drive_held;
      (motor_open || motor_close) [*2];
   endsequence

   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus slave stalled or answered with an error");
   a_idle_rdata: assert property (s_no_read |=> hrdata == 32'h0)
      else $error("read data present without a read");
   a_motor_excl: assert property (!(motor_open && motor_close))
      else $error("motor open and close driven together");
   a_motor_screen: assert property ($rose(motor_open || motor_close) |->
      s_drive_held ##0 screen == SCR_OUTPUT)
      else $error("motor drive off the output screen or too short");
   a_inc_pulse: assert property (output_increment |=> !output_increment)
      else $error("increment pulse longer than one cycle");
   a_dec_pulse: assert property (output_decrement |=>
      !output_decrement && !output_increment)
      else $error("decrement pulse longer than one cycle");
   a_monitor_other: assert property ($past(hresetn) |->
      monitor_loop != measured_value_loop)
      else $error("status monitor shows the lamp channel");
   a_lamp_loop: assert property (loop_two_lamp == measured_value_loop)
      else $error("loop two lamp disagrees with displayed channel");
   a_blink_main: assert property (setpoint_number_blink |-> screen == SCR_MAIN)
      else $error("setpoint number blinks off the main screen");
   a_servo_cursor: assert property (show_position |-> !adjust_secondary)
      else $error("servo build moved the output cursor");
   a_src_range: assert property (loop_one_source <= SRC_PID &&
      loop_two_source <= SRC_PID)
      else $error("output source out of range");
endmodule : cosl_checker

bind cosl_front_panel cosl_checker i_cosl_checker (.hclk, .hresetn, .hsel, .htrans, .hwrite,
   .hready, .hreadyout, .hresp, .hrdata, .screen, .setpoint_number_blink, .loop_two_lamp,
   .measured_value_loop, .monitor_loop, .loop_one_source, .loop_two_source, .motor_open,
   .motor_close, .output_increment, .output_decrement, .adjust_secondary, .show_position);

// [dv/cosl_panel_model.sv]
`timescale 1ns/100ps
module cosl_panel_model
   import cosl_pkg::*;
#(
   parameter int HOLD_CYCLES = 24
) (
   input wire logic hclk,
   output logic [NUM_KEYS-1:0] keys,
   output logic [SP_W-1:0] contact_setpoint_select
);
   initial begin
      keys = '0;
      contact_setpoint_select = '0;
   end

   // a key level stays put over several debounce samples
   task automatic set_key(input int k, input logic v);
      @(posedge hclk);
      keys[k] <= v;
      repeat (HOLD_CYCLES) @(posedge hclk);
   endtask : set_key

   // press and release, so one press is one debounced edge
   task automatic press(input int k);
      set_key(k, 1'b1);
      set_key(k, 1'b0);
   endtask : press

   // all four contacts move at one edge and then hold
   task automatic set_contacts(input logic [SP_W-1:0] v);
      @(posedge hclk);
      contact_setpoint_select <= v;
      repeat (4 * HOLD_CYCLES) @(posedge hclk);
   endtask : set_contacts
endmodule : cosl_panel_model

// [dv/test_controller_output_status_logic.sv]
`timescale 1ns/100ps
module test_controller_output_status_logic
   import cosl_pkg::*;
();
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [NUM_KEYS-1:0] keys;
   logic [SP_W-1:0] contact_setpoint_select, setpoint_number;
   logic [NUM_LAMPS-1:0] status_lamps, monitor_lamps;
   logic loop_two_lamp, measured_value_loop, setpoint_loop, setpoint_number_blink, monitor_loop;
   logic [2:0] screen, loop_one_source, loop_two_source;
   logic motor_open, motor_close, output_increment, output_decrement, adjust_secondary;
   logic show_secondary_control_output, show_position;
   int n_errors = 0;
   int checked = 0;
   int n_inc = 0;
   int n_dec = 0;
   int i, k;
   logic [31:0] pri [5] = '{32'h100, 32'h180, 32'h181, 32'h1c1, 32'h1e1};
   int la [6] = '{2, 1, 0, 2, 2, 1};
   int lb [6] = '{0, 2, 1, 1, 0, 0};

   // short tick keeps debounce and blink counts small
   cosl_front_panel #(.TICK_CYCLES(4)) i_cosl_front_panel (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .keys, .contact_setpoint_select, .status_lamps, .loop_two_lamp, .measured_value_loop,
      .setpoint_loop, .setpoint_number, .setpoint_number_blink, .screen, .monitor_lamps,
      .monitor_loop, .loop_one_source, .loop_two_source, .motor_open, .motor_close,
      .output_increment, .output_decrement, .adjust_secondary, .show_secondary_control_output,
      .show_position);
   cosl_panel_model i_cosl_panel_model (.hclk, .keys, .contact_setpoint_select);

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // pulses are counted so a double action is seen
   always @(posedge hclk) begin
      if (output_increment === 1'b1) n_inc++;
      if (output_decrement === 1'b1) n_dec++;
   end

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // bounded wait for hready; a stuck bus ends the run
   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         n_errors++;
         stop_test();
      end
   endtask : wait_ready

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      r = hrdata;
   endtask : bus

   // two extra edges let the registered outputs follow the write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
      repeat (2) @(posedge hclk);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      bus(1'b0, a, 32'h0, d);
      check(d & m, e);
   endtask : rchk

   // lamp class over 1.25 blink periods: 0 off, 1 steady, 2 blinking
   task automatic lamp(input int n, input int want);
      int ones;
      ones = 0;
      repeat (250) begin
         @(posedge hclk);
         if (status_lamps[n] === 1'b1) ones++;
      end
      check(32'(ones == 0 ? 0 : (ones == 250 ? 1 : 2)), 32'(want));
   endtask : lamp

   task automatic step(input int key, input logic [4:0] ev, input logic [12:0] es);
      i_cosl_panel_model.press(key);
      rchk(REG_VIEW, 32'h1f, {27'h0, ev});
      rchk(REG_SETPOINT, 32'h1fff, {19'h0, es});
   endtask : step

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values, unmapped and read-only places
      rchk(REG_CONFIG, 32'hffffffff, 32'h0);
      rchk(REG_VIEW, 32'hfff, 32'hb40);
      rchk(8'h14, 32'hffffffff, 32'h0);
      wr(REG_SETPOINT, 32'hfff);
      rchk(REG_SETPOINT, 32'hffffffff, 32'h0);
      // priority chain built up from the lowest level
      wr(REG_CONFIG, 32'h00c);
      for (i = 0; i < 5; i++) begin
         wr(REG_LOOP_ONE, pri[i]);
         wr(REG_LOOP_TWO, pri[i]);
         check({26'h0, loop_one_source, loop_two_source}, {26'h0, 3'(4 - i), 3'(4 - i)});
      end
      wr(REG_LOOP_ONE, 32'h1c1);
      wr(REG_CONFIG, 32'h004);
      check({29'h0, loop_one_source}, 32'h2);
      // status lamps, steady and blinking
      wr(REG_CONFIG, 32'h0);
      wr(REG_LOOP_TWO, 32'h0);
      wr(REG_LOOP_ONE, 32'h22d);
      for (i = 0; i < 6; i++) lamp(i, la[i]);
      wr(REG_CONFIG, 32'h0c0);
      wr(REG_LOOP_ONE, 32'h012);
      for (i = 0; i < 6; i++) lamp(i, lb[i]);
      // screens and setpoint number editing in a two-loop, two-input build
      wr(REG_CONFIG, 32'h011);
      wr(REG_LOOP_ONE, 32'h0);
      wr(REG_LOOP_TWO, 32'h200);
      check({26'h0, monitor_lamps}, 32'h20);
      step(KEY_SCREEN, 5'h01, 13'h0000);
      step(KEY_SCREEN, 5'h02, 13'h0000);
      step(KEY_SCREEN, 5'h03, 13'h0000);
      step(KEY_SCREEN, 5'h00, 13'h0000);
      step(KEY_SCREEN, 5'h01, 13'h0000);
      step(KEY_SETPOINT, 5'h00, 13'h1000);
      step(KEY_SETPOINT, 5'h00, 13'h1100);
      step(KEY_UP, 5'h00, 13'h1200);
      step(KEY_DOWN, 5'h00, 13'h1100);
      step(KEY_SETPOINT, 5'h00, 13'h1200);
      // the edit value field keeps the last edited number after confirm
      step(KEY_CONFIRM, 5'h00, 13'h0202);
      check({27'h0, setpoint_number, setpoint_number_blink}, 32'h4);
      step(KEY_VIEW, 5'h08, 13'h0202);
      check({30'h0, measured_value_loop, setpoint_loop}, 32'h3);
      check({26'h0, status_lamps}, 32'h20);
      step(KEY_SETPOINT, 5'h08, 13'h1102);
      step(KEY_CONFIRM, 5'h08, 13'h0112);
      step(KEY_GROUP, 5'h0c, 13'h0112);
      check({30'h0, measured_value_loop, setpoint_loop}, 32'h3);
      step(KEY_VIEW, 5'h08, 13'h0112);
      step(KEY_VIEW, 5'h10, 13'h0112);
      check({30'h0, measured_value_loop, setpoint_loop}, 32'h1);
      step(KEY_VIEW, 5'h00, 13'h0112);
      // cascade and contact selection lock the setpoint key out
      wr(REG_CONFIG, 32'h031);
      step(KEY_VIEW, 5'h08, 13'h0112);
      step(KEY_SETPOINT, 5'h08, 13'h0112);
      step(KEY_VIEW, 5'h10, 13'h0112);
      step(KEY_VIEW, 5'h00, 13'h0112);
      wr(REG_CONFIG, 32'h0c1);
      i_cosl_panel_model.set_contacts(4'h5);
      step(KEY_SETPOINT, 5'h00, 13'h0115);
      // contacts assigned to both loops set loop two as well
      wr(REG_CONFIG, 32'h1c1);
      rchk(REG_SETPOINT, 32'hff, 32'h55);
      // servo with feedback, manual: keys drive the motor while held
      wr(REG_CONFIG, 32'h00c);
      wr(REG_LOOP_ONE, 32'h020);
      check({30'h0, show_secondary_control_output, show_position}, 32'h1);
      i_cosl_panel_model.press(KEY_SCREEN);
      check({29'h0, screen}, 32'h1);
      for (i = 0; i < 2; i++) begin
         i_cosl_panel_model.set_key(KEY_UP + i, 1'b1);
         check({30'h0, motor_open, motor_close}, 32'(2 - i));
         i_cosl_panel_model.set_key(KEY_UP + i, 1'b0);
         check({30'h0, motor_open, motor_close}, 32'h0);
      end
      // two-output build: cursor picks the output, one press one step
      wr(REG_CONFIG, 32'h002);
      check({30'h0, show_secondary_control_output, show_position}, 32'h2);
      i_cosl_panel_model.press(KEY_SELECT);
      check({31'h0, adjust_secondary}, 32'h1);
      i = n_inc;
      k = n_dec;
      i_cosl_panel_model.press(KEY_UP);
      i_cosl_panel_model.press(KEY_DOWN);
      check(32'((n_inc - i) * 16 + (n_dec - k)), 32'h11);
      // a second reset in mid-run clears the settings
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(REG_CONFIG, 32'hffffffff, 32'h0);
      check({29'h0, screen}, 32'h0);
      stop_test();
   end
endmodule : test_controller_output_status_logic
